// >>> tas_pkg.sv
package tas_pkg;
	// ----------------------------------------
	// Slot counts
	// ----------------------------------------
	localparam int          VOICE_SLOTS   = 132;
	localparam int          PATTERN_SLOTS = 12;
	localparam logic [7:0]  VOICE_LAST    = 8'h83;
	localparam logic [3:0]  PATTERN_LAST  = 4'hb;
	localparam logic [7:0]  VOICE_FIRST   = 8'h00;
	localparam logic [3:0]  PATTERN_FIRST = 4'h0;
	// ----------------------------------------
	// Record type tags
	// ----------------------------------------
	localparam logic [2:0]  TAG_VOICE     = 3'h1;
	localparam logic [2:0]  TAG_PATTERN   = 3'h2;
	localparam logic [2:0]  TAG_NULL_V    = 3'h3;
	localparam logic [2:0]  TAG_NULL_P    = 3'h4;
	localparam logic [2:0]  TAG_CNT_RST   = 3'h5;
	localparam logic [2:0]  TAG_END       = 3'h6;
	// ----------------------------------------
	// Memory-full flashing
	// ----------------------------------------
	localparam int          FLASH_MS      = 250;
	localparam int          CLK_KHZ       = 50000;
	localparam int          FLASH_CYC     = FLASH_MS * CLK_KHZ;
	localparam logic [3:0]  FLASH_TOGGLES = 4'h8;
	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_CHECK   = 4'b0001,
		ST_SEND    = 4'b0010,
		ST_WAIT    = 4'b0011,
		ST_LOAD    = 4'b0100,
		ST_VERIFY  = 4'b0101,
		ST_FAIL    = 4'b0110,
		ST_DONE    = 4'b0111
	} tas_state_e;
	typedef enum logic [2:0] {
		OP_NONE    = 3'b000,
		OP_SV1     = 3'b001,
		OP_SVALL   = 3'b010,
		OP_SP1     = 3'b011,
		OP_SPALL   = 3'b100,
		OP_LV1     = 3'b101,
		OP_LP1     = 3'b110,
		OP_LALL    = 3'b111
	} tas_op_e;
endpackage

// >>> tas_skid.sv
`timescale 1ns/100ps
`default_nettype none
module tas_skid #(
	parameter int W = 12
) (
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data,
	input  wire logic         flush
);
	// ----------------------------------------
	// Two-entry buffer
	// ----------------------------------------
	logic [W-1:0] mem_r [2];
	logic [1:0]   cnt_r;
	logic         rd_r;
	logic         wr_r;
	logic         push;
	logic         pop;

	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = mem_r[rd_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 2'h0;
			rd_r  <= 1'b0;
			wr_r  <= 1'b0;
		end else if (flush) begin
			cnt_r <= 2'h0;
			rd_r  <= 1'b0;
			wr_r  <= 1'b0;
		end else begin
			if (push)
				wr_r <= ~wr_r;
			if (pop)
				rd_r <= ~rd_r;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push)
			mem_r[wr_r] <= in_data;
	end
endmodule
`default_nettype wire

// >>> tas_seq.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - One-voice save writes working copy, motor on/off
// - Save-all voices writes all 132 slots
// - Empty slots produce null records in bulk saves
// - Display shows slot currently being written
// - Abort key stops a save in progress
// - Empty pattern single save: error tone only
// - Save-all patterns writes twelve slots
// - Undecodable tape data aborts load with tone
// - One-voice load: indicator, skip, load working
// - One-voice load leaves stored slots untouched
// - One-pattern load overwrites selected slot
// - Bulk load sorts records, two counters
// - Counter-reset record resets both slot counters
// - Store record at counter, then advance
// - Null record erases the addressed slot
// - Bulk load ends on abort or end marker
// - Bulk saves end with end marker
// - Memory full: tone, motor off, flash indicator
// - Free old pattern only when record lands
// - Motor output drives recorder transport
// - Verify runs motor, checks, never writes memory
module tas_seq (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        store_one_voice_cmd,
	input  wire logic        store_every_voice_cmd,
	input  wire logic        store_one_pattern_cmd,
	input  wire logic        store_every_pattern_cmd,
	input  wire logic        fetch_one_voice_cmd,
	input  wire logic        fetch_one_pattern_cmd,
	input  wire logic        fetch_all_cmd,
	input  wire logic        verify_cmd,
	input  wire logic        abort_key,
	input  wire logic [3:0]  sel_pattern,
	input  wire logic [131:0] voice_present,
	input  wire logic [11:0] pattern_present,
	output logic             rec_valid,
	input  wire logic        rec_ready,
	output logic      [2:0]  rec_tag,
	output logic      [7:0]  rec_slot,
	output logic             rec_working,
	input  wire logic        rx_valid,
	input  wire logic [2:0]  rx_tag,
	input  wire logic        rx_error,
	input  wire logic        rx_detect,
	input  wire logic        mem_full,
	output logic             mem_we,
	output logic             mem_erase,
	output logic             mem_is_pattern,
	output logic             mem_to_working,
	output logic      [7:0]  mem_slot,
	output logic             motor_on,
	output logic             error_tone,
	output logic      [7:0]  slot_display,
	output logic             load_led,
	output logic             full_led,
	output logic             busy
);
	// ----------------------------------------
	// Pin-side input synchronisers
	// ----------------------------------------
	logic [1:0] ab_s1_r;
	logic [1:0] ab_s2_r;
	logic       abort_seen;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ab_s1_r <= 2'h0;
			ab_s2_r <= 2'h0;
		end else begin
			ab_s1_r <= {rx_detect, abort_key};
			ab_s2_r <= ab_s1_r;
		end
	end
	assign abort_seen = ab_s2_r[0];

	// ----------------------------------------
	// State
	// ----------------------------------------
	tas_pkg::tas_state_e st_r;
	tas_pkg::tas_op_e    op_r;
	logic [7:0]          vcnt_r;
	logic [3:0]          pcnt_r;
	logic                end_sent_r;
	logic                hdr_sent_r;
	logic                bulk;
	logic                pat_op;
	logic                last_slot;
	logic                slot_full;
	logic                q_valid;
	logic                q_ready;
	logic [11:0]         q_data;
	logic                q_flush;

	assign bulk      = (op_r == tas_pkg::OP_SVALL) || (op_r == tas_pkg::OP_SPALL);
	assign pat_op    = (op_r == tas_pkg::OP_SPALL) || (op_r == tas_pkg::OP_SP1);
	assign last_slot = pat_op ? (pcnt_r == tas_pkg::PATTERN_LAST) : (vcnt_r == tas_pkg::VOICE_LAST);
	assign slot_full = pat_op ? pattern_present[pcnt_r] : voice_present[vcnt_r];

	// ----------------------------------------
	// Record emission into the buffer
	// ----------------------------------------
	always_comb begin
		q_valid = 1'b0;
		q_data  = 12'h000;
		if (st_r == tas_pkg::ST_SEND) begin
			q_valid = 1'b1;
			if (!bulk)
				q_data = {pat_op ? tas_pkg::TAG_PATTERN : tas_pkg::TAG_VOICE, 1'b1,
					pat_op ? {4'h0, sel_pattern} : 8'h00};
			else if (!hdr_sent_r)
				q_data = {tas_pkg::TAG_CNT_RST, 9'h000};
			else if (end_sent_r)
				q_data = {tas_pkg::TAG_END, 9'h000};
			else if (slot_full)
				q_data = {pat_op ? tas_pkg::TAG_PATTERN : tas_pkg::TAG_VOICE, 1'b0,
					pat_op ? {4'h0, pcnt_r} : vcnt_r};
			else
				q_data = {pat_op ? tas_pkg::TAG_NULL_P : tas_pkg::TAG_NULL_V, 1'b0,
					pat_op ? {4'h0, pcnt_r} : vcnt_r};
		end
	end
	assign q_flush = abort_seen && (st_r == tas_pkg::ST_SEND || st_r == tas_pkg::ST_WAIT);

	tas_skid #(
		.W (12)
	) u_buf (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.in_valid  (q_valid),
		.in_ready  (q_ready),
		.in_data   (q_data),
		.out_valid (rec_valid),
		.out_ready (rec_ready),
		.out_data  ({rec_tag, rec_working, rec_slot}),
		.flush     (q_flush)
	);

	// ----------------------------------------
	// Main sequencer
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_r       <= tas_pkg::ST_IDLE;
			op_r       <= tas_pkg::OP_NONE;
			vcnt_r     <= tas_pkg::VOICE_FIRST;
			pcnt_r     <= tas_pkg::PATTERN_FIRST;
			hdr_sent_r <= 1'b0;
			end_sent_r <= 1'b0;
		end else begin
			case (st_r)
				tas_pkg::ST_IDLE: begin
					hdr_sent_r <= 1'b0;
					end_sent_r <= 1'b0;
					vcnt_r     <= tas_pkg::VOICE_FIRST;
					pcnt_r     <= tas_pkg::PATTERN_FIRST;
					if (store_one_voice_cmd) begin
						op_r <= tas_pkg::OP_SV1;
						st_r <= tas_pkg::ST_SEND;
					end else if (store_every_voice_cmd) begin
						op_r <= tas_pkg::OP_SVALL;
						st_r <= tas_pkg::ST_SEND;
					end else if (store_one_pattern_cmd) begin
						op_r <= tas_pkg::OP_SP1;
						st_r <= tas_pkg::ST_CHECK;
					end else if (store_every_pattern_cmd) begin
						op_r <= tas_pkg::OP_SPALL;
						st_r <= tas_pkg::ST_SEND;
					end else if (fetch_one_voice_cmd) begin
						op_r <= tas_pkg::OP_LV1;
						st_r <= tas_pkg::ST_LOAD;
					end else if (fetch_one_pattern_cmd) begin
						op_r <= tas_pkg::OP_LP1;
						st_r <= tas_pkg::ST_LOAD;
					end else if (fetch_all_cmd) begin
						op_r <= tas_pkg::OP_LALL;
						st_r <= tas_pkg::ST_LOAD;
					end else if (verify_cmd) begin
						op_r <= tas_pkg::OP_NONE;
						st_r <= tas_pkg::ST_VERIFY;
					end
				end
				tas_pkg::ST_CHECK: begin
					// Empty selection: tone, no motor, no record
					st_r <= pattern_present[sel_pattern] ? tas_pkg::ST_SEND : tas_pkg::ST_FAIL;
				end
				tas_pkg::ST_SEND: begin
					if (abort_seen)
						st_r <= tas_pkg::ST_DONE;
					else if (q_ready) begin
						if (!bulk || end_sent_r)
							st_r <= tas_pkg::ST_WAIT;
						else if (!hdr_sent_r)
							hdr_sent_r <= 1'b1;
						else if (last_slot)
							end_sent_r <= 1'b1;
						else if (pat_op)
							pcnt_r <= pcnt_r + 4'h1;
						else
							vcnt_r <= vcnt_r + 8'h01;
					end
				end
				tas_pkg::ST_WAIT: begin
					// Hold the motor until the last record has left the buffer
					if (abort_seen || !rec_valid)
						st_r <= tas_pkg::ST_DONE;
				end
				tas_pkg::ST_LOAD: begin
					if (abort_seen)
						st_r <= tas_pkg::ST_DONE;
					else if (rx_error)
						st_r <= tas_pkg::ST_FAIL;
					else if (rx_valid && mem_full)
						st_r <= tas_pkg::ST_FAIL;
					else if (rx_valid) begin
						case (rx_tag)
							tas_pkg::TAG_CNT_RST: begin
								vcnt_r <= tas_pkg::VOICE_FIRST;
								pcnt_r <= tas_pkg::PATTERN_FIRST;
							end
							tas_pkg::TAG_VOICE, tas_pkg::TAG_NULL_V: begin
								if (op_r == tas_pkg::OP_LV1 && rx_tag == tas_pkg::TAG_VOICE)
									st_r <= tas_pkg::ST_DONE;
								else if (op_r == tas_pkg::OP_LALL)
									vcnt_r <= (vcnt_r == tas_pkg::VOICE_LAST) ? vcnt_r : vcnt_r + 8'h01;
							end
							tas_pkg::TAG_PATTERN, tas_pkg::TAG_NULL_P: begin
								if (op_r == tas_pkg::OP_LP1 && rx_tag == tas_pkg::TAG_PATTERN)
									st_r <= tas_pkg::ST_DONE;
								else if (op_r == tas_pkg::OP_LALL)
									pcnt_r <= (pcnt_r == tas_pkg::PATTERN_LAST) ? pcnt_r : pcnt_r + 4'h1;
							end
							tas_pkg::TAG_END: begin
								if (op_r == tas_pkg::OP_LALL)
									st_r <= tas_pkg::ST_DONE;
							end
							default: begin
								st_r <= tas_pkg::ST_FAIL;
							end
						endcase
					end
				end
				tas_pkg::ST_VERIFY: begin
					if (abort_seen)
						st_r <= tas_pkg::ST_DONE;
					else if (rx_error)
						st_r <= tas_pkg::ST_FAIL;
				end
				tas_pkg::ST_FAIL: begin
					st_r <= tas_pkg::ST_DONE;
				end
				tas_pkg::ST_DONE: begin
					if (!abort_seen)
						st_r <= tas_pkg::ST_IDLE;
				end
				default: begin
					st_r <= tas_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Memory writes on load
	// ----------------------------------------
	logic ld_ok;
	logic is_v;
	logic is_p;
	logic is_nv;
	logic is_np;
	assign ld_ok = (st_r == tas_pkg::ST_LOAD) && rx_valid && !rx_error && !mem_full && !abort_seen;
	assign is_v  = rx_tag == tas_pkg::TAG_VOICE;
	assign is_p  = rx_tag == tas_pkg::TAG_PATTERN;
	assign is_nv = rx_tag == tas_pkg::TAG_NULL_V;
	assign is_np = rx_tag == tas_pkg::TAG_NULL_P;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mem_we         <= 1'b0;
			mem_erase      <= 1'b0;
			mem_is_pattern <= 1'b0;
			mem_to_working <= 1'b0;
			mem_slot       <= 8'h00;
		end else begin
			mem_we         <= 1'b0;
			mem_erase      <= 1'b0;
			mem_to_working <= 1'b0;
			if (ld_ok) begin
				case (op_r)
					tas_pkg::OP_LV1: begin
						// Working copy only, stored slots untouched
						mem_we         <= is_v;
						mem_to_working <= is_v;
						mem_is_pattern <= 1'b0;
						mem_slot       <= 8'h00;
					end
					tas_pkg::OP_LP1: begin
						// Old pattern freed by this same write
						mem_we         <= is_p;
						mem_is_pattern <= 1'b1;
						mem_slot       <= {4'h0, sel_pattern};
					end
					tas_pkg::OP_LALL: begin
						mem_we         <= is_v || is_p;
						mem_erase      <= is_nv || is_np;
						mem_is_pattern <= is_p || is_np;
						mem_slot       <= (is_p || is_np) ? {4'h0, pcnt_r} : vcnt_r;
					end
					default: begin
						mem_we <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Panel and recorder outputs
	// ----------------------------------------
	logic [$clog2(tas_pkg::FLASH_CYC)-1:0] fl_cnt_r;
	logic [3:0]                            fl_left_r;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			motor_on     <= 1'b0;
			error_tone   <= 1'b0;
			slot_display <= 8'h00;
			load_led     <= 1'b0;
		end else begin
			motor_on   <= (st_r == tas_pkg::ST_SEND) || (st_r == tas_pkg::ST_WAIT)
				|| (st_r == tas_pkg::ST_LOAD) || (st_r == tas_pkg::ST_VERIFY);
			error_tone <= (st_r == tas_pkg::ST_FAIL);
			if (rec_valid && rec_ready)
				slot_display <= rec_slot;
			if (st_r == tas_pkg::ST_LOAD && ab_s2_r[1])
				load_led <= 1'b1;
			else if (st_r == tas_pkg::ST_IDLE)
				load_led <= 1'b0;
		end
	end

	// Flashing lasts a fixed number of toggles so the user can spot it after the tone
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fl_cnt_r  <= '0;
			fl_left_r <= 4'h0;
			full_led  <= 1'b0;
		end else if (st_r == tas_pkg::ST_LOAD && rx_valid && mem_full && !rx_error && !abort_seen) begin
			fl_left_r <= tas_pkg::FLASH_TOGGLES;
			fl_cnt_r  <= '0;
			full_led  <= 1'b1;
		end else if (fl_left_r != 4'h0) begin
			if (fl_cnt_r == ($clog2(tas_pkg::FLASH_CYC))'(tas_pkg::FLASH_CYC - 1)) begin
				fl_cnt_r  <= '0;
				fl_left_r <= fl_left_r - 4'h1;
				full_led  <= (fl_left_r != 4'h1) && !full_led;
			end else
				fl_cnt_r <= fl_cnt_r + 1'b1;
		end
	end

	assign busy = (st_r != tas_pkg::ST_IDLE);
endmodule
`default_nettype wire

// >>> tas_seq_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module tas_seq_assertions (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        store_one_voice_cmd,
	input wire logic        store_every_voice_cmd,
	input wire logic        store_one_pattern_cmd,
	input wire logic        store_every_pattern_cmd,
	input wire logic        fetch_one_voice_cmd,
	input wire logic        fetch_one_pattern_cmd,
	input wire logic        fetch_all_cmd,
	input wire logic        verify_cmd,
	input wire logic [3:0]  sel_pattern,
	input wire logic [11:0] pattern_present,
	input wire logic        rx_valid,
	input wire logic [2:0]  rx_tag,
	input wire logic        rx_error,
	input wire logic        mem_full,
	input wire logic        mem_we,
	input wire logic        mem_erase,
	input wire logic        mem_is_pattern,
	input wire logic        mem_to_working,
	input wire logic        motor_on,
	input wire logic        error_tone,
	input wire logic        full_led,
	input wire logic        busy
);
	// --------
	// Operation tracking
	// --------
	logic [2:0] md_r;
	wire logic  any_st  = store_one_voice_cmd | store_every_voice_cmd | store_one_pattern_cmd | store_every_pattern_cmd;
	wire logic  empty_go = store_one_pattern_cmd && !busy && !store_one_voice_cmd && !store_every_voice_cmd
		&& !pattern_present[sel_pattern];
	wire logic  loading = (md_r == 3'h2 || md_r == 3'h3 || md_r == 3'h4) && motor_on;
	// Mode latched only while idle, since the block ignores commands when busy
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			md_r <= 3'h0;
		else if (!busy)
			md_r <= any_st ? 3'h1 : fetch_one_voice_cmd ? 3'h2 : fetch_one_pattern_cmd ? 3'h3
				: fetch_all_cmd ? 3'h4 : verify_cmd ? 3'h5 : 3'h0;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_save_motor_start: assert property (store_one_voice_cmd && !busy |-> ##2 motor_on)
		else $error("motor late after save");
	a_empty_honk: assert property (empty_go |-> ##[1:3] error_tone)
		else $error("no tone for empty pattern");
	a_empty_quiet: assert property (empty_go |=> !motor_on [*6])
		else $error("motor ran for empty pattern");
	a_tone_pulse: assert property (error_tone |=> !error_tone)
		else $error("tone longer than a cycle");
	a_bad_data_abort: assert property (loading && rx_error |-> ##[1:5] error_tone ##[0:4] !motor_on)
		else $error("decode failure not aborted");
	a_verify_no_write: assert property (md_r == 3'h5 |-> !mem_we && !mem_erase)
		else $error("verify wrote memory");
	a_bulk_store: assert property (md_r == 3'h4 && motor_on && rx_valid && !mem_full
		&& (rx_tag == tas_pkg::TAG_VOICE || rx_tag == tas_pkg::TAG_PATTERN)
		|=> mem_we && mem_is_pattern == ($past(rx_tag) == tas_pkg::TAG_PATTERN))
		else $error("bulk record not stored");
	a_null_erase: assert property (md_r == 3'h4 && motor_on && rx_valid && !mem_full
		&& (rx_tag == tas_pkg::TAG_NULL_V || rx_tag == tas_pkg::TAG_NULL_P) |=> mem_erase && !mem_we)
		else $error("null record not erased");
	a_one_voice_load: assert property (md_r == 3'h2 && motor_on && rx_valid && !mem_full
		&& rx_tag == tas_pkg::TAG_VOICE |=> mem_we && mem_to_working && !mem_is_pattern)
		else $error("voice not loaded to working copy");
	a_skip_other: assert property (md_r == 3'h2 && rx_valid && rx_tag != tas_pkg::TAG_VOICE
		|=> !mem_we && !mem_erase)
		else $error("non-voice record written");
	a_full_stop: assert property (loading && rx_valid && mem_full
		|=> !mem_we ##[0:4] error_tone ##[0:8] (!motor_on && full_led))
		else $error("memory full not handled");
	c_bulk_end: cover property (md_r == 3'h4 && rx_valid && rx_tag == tas_pkg::TAG_END);
	c_tone: cover property (error_tone);
	c_full: cover property (full_led);
endmodule
bind tas_seq tas_seq_assertions u_chk (.*);
`default_nettype wire

// >>> tas_tape_model.sv
`timescale 1ns/100ps
`default_nettype none
module tas_tape_model (
	input  wire logic        sys_clk,
	input  wire logic        motor_on,
	input  wire logic        rec_valid,
	output logic             rec_ready,
	input  wire logic [2:0]  rec_tag,
	input  wire logic [7:0]  rec_slot,
	input  wire logic        rec_working,
	output logic             rx_valid,
	output logic      [2:0]  rx_tag
);
	// --------
	// Recorder
	// --------
	logic [11:0] log_q[$];
	logic [1:0]  cyc = 2'h0;
	initial begin
		rx_valid = 1'b0;
		rx_tag   = 3'h0;
	end
	// Tape only moves with the motor; one stall in four exercises the buffer
	assign rec_ready = motor_on && cyc != 2'h0;
	always @(posedge sys_clk) begin
		cyc <= cyc + 2'h1;
		if (rec_valid && rec_ready)
			log_q.push_back({rec_working, rec_tag, rec_slot});
	end
	task automatic play(input logic [2:0] tag);
		rx_valid = 1'b1;
		rx_tag   = tag;
		@(posedge sys_clk) #1;
		rx_valid = 1'b0;
		rx_tag   = ~tag;
		@(posedge sys_clk) #1;
	endtask
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic sys_clk, nrst, abort_key, rx_error, rx_detect, mem_full, rec_ready, rx_valid, rec_valid, rec_working;
	logic store_one_voice_cmd, store_every_voice_cmd, store_one_pattern_cmd, store_every_pattern_cmd;
	logic fetch_one_voice_cmd, fetch_one_pattern_cmd, fetch_all_cmd, verify_cmd, mem_we, mem_erase;
	logic mem_is_pattern, mem_to_working, motor_on, error_tone, load_led, full_led, busy;
	logic [3:0]   sel_pattern;
	logic [131:0] voice_present;
	logic [11:0]  pattern_present;
	logic [2:0]   rec_tag, rx_tag;
	logic [7:0]   rec_slot, mem_slot, slot_display;
	logic [10:0]  mq[$];
	int           err_total = 0, compares = 0, tones = 0;
	tas_seq u_dut (.*);
	tas_tape_model u_tape (.*);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		tones <= tones + (error_tone === 1'b1);
		if (mem_we === 1'b1 || mem_erase === 1'b1)
			mq.push_back({mem_erase, mem_is_pattern, mem_to_working, mem_slot});
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic go(ref logic c);
		c = 1'b1;
		tick(1);
		c = 1'b0;
		tick(1);
	endtask
	task automatic wait_idle(input int lim);
		for (int n = 0; busy !== 1'b0; n++) begin
			if (n > lim) begin
				err_total++;
				$display("ERROR t=%0t busy stuck got=%h exp=%h", $time, busy, 1'b0);
				complete_run();
			end
			tick(1);
		end
		tick(3);
	endtask
	task automatic stream(input int n, input logic [131:0] p, input logic [2:0] tr, input logic [2:0] tn);
		chk(u_tape.log_q.size(), n + 2);
		if (u_tape.log_q.size() != n + 2)
			return;
		chk(u_tape.log_q[0][10:8], tas_pkg::TAG_CNT_RST);
		for (int i = 0; i < n; i++)
			chk(u_tape.log_q[i+1][10:0], {p[i] ? tr : tn, 8'(i)});
		chk(u_tape.log_q[n+1][10:8], tas_pkg::TAG_END);
		chk(motor_on, 1'b0);
	endtask
	task automatic t_save();
		int t0;
		t0 = tones;
		u_tape.log_q.delete();
		go(store_one_voice_cmd);
		tick(1);
		chk(motor_on, 1'b1);
		wait_idle(200);
		chk(motor_on, 1'b0);
		chk(u_tape.log_q.size(), 1);
		chk(u_tape.log_q[0][11:8], {1'b1, tas_pkg::TAG_VOICE});
		u_tape.log_q.delete();
		go(store_one_pattern_cmd);
		wait_idle(50);
		chk(tones - t0, 1);
		chk(u_tape.log_q.size(), 0);
		sel_pattern = 4'h1;
		go(store_one_pattern_cmd);
		wait_idle(200);
		chk(u_tape.log_q[0][11:8], {1'b1, tas_pkg::TAG_PATTERN});
		$display("test single saves done");
	endtask
	task automatic t_bulk_save();
		u_tape.log_q.delete();
		go(store_every_voice_cmd);
		wait_idle(3000);
		stream(132, voice_present, tas_pkg::TAG_VOICE, tas_pkg::TAG_NULL_V);
		u_tape.log_q.delete();
		go(store_every_pattern_cmd);
		wait_idle(500);
		stream(12, {120'h0, pattern_present}, tas_pkg::TAG_PATTERN, tas_pkg::TAG_NULL_P);
		u_tape.log_q.delete();
		go(store_every_voice_cmd);
		tick(20);
		abort_key = 1'b1;
		// The sequencer parks until the key is let go, so release it before waiting
		tick(4);
		abort_key = 1'b0;
		wait_idle(50);
		chk(motor_on, 1'b0);
		chk(u_tape.log_q.size() < 134, 1'b1);
		chk(slot_display, u_tape.log_q[$][7:0]);
		$display("test bulk saves done");
	endtask
	task automatic t_loads();
		logic [10:0] ex[5] = '{11'h000, 11'h001, 11'h600, 11'h201, 11'h402};
		mq.delete();
		rx_detect = 1'b1;
		go(fetch_one_voice_cmd);
		tick(3);
		chk(load_led, 1'b1);
		u_tape.play(tas_pkg::TAG_PATTERN);
		u_tape.play(tas_pkg::TAG_VOICE);
		wait_idle(50);
		rx_detect = 1'b0;
		chk(mq.size(), 1);
		chk(mq[0][10:8], 3'h1);
		mq.delete();
		sel_pattern = 4'h7;
		go(fetch_one_pattern_cmd);
		tick(3);
		u_tape.play(tas_pkg::TAG_VOICE);
		u_tape.play(tas_pkg::TAG_PATTERN);
		wait_idle(50);
		chk(mq.size(), 1);
		chk(mq[0], 11'h207);
		mq.delete();
		go(fetch_all_cmd);
		tick(3);
		foreach (ex[i]) begin
			if (i == 0)
				u_tape.play(tas_pkg::TAG_CNT_RST);
			u_tape.play(ex[i][10] ? (ex[i][9] ? tas_pkg::TAG_NULL_P : tas_pkg::TAG_NULL_V)
				: (ex[i][9] ? tas_pkg::TAG_PATTERN : tas_pkg::TAG_VOICE));
		end
		u_tape.play(tas_pkg::TAG_END);
		wait_idle(50);
		chk(mq.size(), 5);
		foreach (ex[i])
			chk(mq[i], ex[i]);
		$display("test loads done");
	endtask
	task automatic t_faults();
		int t0;
		t0 = tones;
		mq.delete();
		go(verify_cmd);
		tick(3);
		chk(motor_on, 1'b1);
		u_tape.play(tas_pkg::TAG_VOICE);
		rx_error = 1'b1;
		tick(1);
		rx_error = 1'b0;
		wait_idle(50);
		chk(mq.size(), 0);
		go(fetch_all_cmd);
		tick(3);
		rx_error = 1'b1;
		tick(1);
		rx_error = 1'b0;
		wait_idle(50);
		chk(motor_on, 1'b0);
		chk(tones - t0, 2);
		go(fetch_all_cmd);
		tick(3);
		u_tape.play(3'h7);
		wait_idle(50);
		chk(motor_on, 1'b0);
		chk(tones - t0, 3);
		go(fetch_all_cmd);
		tick(3);
		mem_full = 1'b1;
		u_tape.play(tas_pkg::TAG_VOICE);
		// Flashing runs for seconds, so only the start of it is watched
		tick(10);
		chk(mq.size(), 0);
		chk({motor_on, full_led}, 2'h1);
		chk(tones - t0, 4);
		$display("test faults done");
	endtask
	initial begin
		{nrst, abort_key, rx_error, rx_detect, mem_full, store_one_voice_cmd, store_every_voice_cmd} = '0;
		{store_one_pattern_cmd, store_every_pattern_cmd, fetch_one_voice_cmd, fetch_one_pattern_cmd} = '0;
		{fetch_all_cmd, verify_cmd} = '0;
		voice_present = {33{4'h9}};
		pattern_present = 12'h5a3;
		sel_pattern = 4'h2;
		tick(20);
		nrst = 1'b1;
		t_save();
		t_bulk_save();
		t_loads();
		t_faults();
		complete_run();
	end
endmodule
`default_nettype wire
